/* File: srhs_link.sv */
// Slave end of the five-wire interprocessor_link with ready handshake
`timescale 1ns/1ps
`default_nettype none
`include "srhs_params.svh"

module srhs_link
    import srhs_pkg::*;
#(
    parameter int FRAME_WORDS_MAX = `SRHS_FRAME_WORDS_MAX,
    localparam int WIDX = $clog2(FRAME_WORDS_MAX),
    localparam int CW = $clog2(FRAME_WORDS_MAX + 1),
    localparam int BW = WIDX + 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic master_ready_line,
    output logic slave_ready_line,
    input wire logic tx_wr_en,
    input wire logic [WIDX-1:0] tx_wr_idx,
    input wire logic [`SRHS_WORD_BITS-1:0] tx_wr_data,
    input wire logic [CW-1:0] frame_words,
    input wire logic send,
    input wire logic [WIDX-1:0] rx_rd_idx,
    output logic [`SRHS_WORD_BITS-1:0] rx_rd_data,
    output logic frame_done,
    output logic master_ready,
    output logic master_wake,
    output logic busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Bit counters split into word and bit fields, so depth is a power of two
    if (FRAME_WORDS_MAX < 2 || (FRAME_WORDS_MAX & (FRAME_WORDS_MAX - 1)) != 0) begin : g_chk
        $error("FRAME_WORDS_MAX must be a power of two, at least 2");
    end

    localparam int PREP_CYC = `SRHS_PREP_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    srhs_state_t state;
    logic pend;
    logic [3:0] prep_cnt;
    logic [BW-1:0] last_bit;
    logic [`SRHS_WORD_BITS-1:0] tx_buf [FRAME_WORDS_MAX];
    logic [`SRHS_WORD_BITS-1:0] rx_buf [FRAME_WORDS_MAX];
    logic mr_s1;
    logic mr_s2;
    logic mr_s3;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic done_evt;
    logic len_ok;
    logic prep_end;
    logic accept;
    logic [CW-1:0] fw_m1;
    logic [BW-1:0] rcnt;
    logic [BW-1:0] fcnt;
    logic miso_q;
    logic done_tgl;
    logic link_idle;

    ////////////////////////////////////////////////////////////////////////////
    // System side: handshake control

    // Header word is counted in frame_words, so one word is the least frame
    assign len_ok = (frame_words >= CW'(`SRHS_HDR_WORDS))
        && (frame_words <= CW'(FRAME_WORDS_MAX));
    assign prep_end = (state == SRHS_PREP) && (prep_cnt == 4'h0);
    assign accept = len_ok && (((state == SRHS_IDLE) && send)
        || (prep_end && (pend || send)));
    assign done_evt = done_s2 ^ done_s3;
    assign fw_m1 = frame_words - CW'(1);

    // Ready line is a plain decode of the state flop
    assign slave_ready_line = (state == SRHS_READY);
    assign busy = (state != SRHS_IDLE);

    // Handshake state machine
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= SRHS_IDLE;
            prep_cnt <= 4'h0;
        end else begin
            case (state)
                SRHS_IDLE: begin
                    if (accept) begin
                        state <= SRHS_READY;
                    end
                end
                SRHS_READY: begin
                    // Clock burst over: drop ready and give software time
                    if (done_evt) begin
                        state <= SRHS_PREP;
                        prep_cnt <= 4'(PREP_CYC - 1);
                    end
                end
                SRHS_PREP: begin
                    if (prep_cnt != 4'h0) begin
                        prep_cnt <= prep_cnt - 4'h1;
                    end else if (accept) begin
                        state <= SRHS_READY;
                    end else begin
                        state <= SRHS_IDLE;
                    end
                end
                default: begin
                    state <= SRHS_IDLE;
                end
            endcase
        end
    end

    // A send that cannot start yet is held; a new send beats the clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pend <= 1'b0;
        end else if (send && !accept) begin
            pend <= 1'b1;
        end else if (accept || prep_end) begin
            pend <= 1'b0;
        end
    end

    // Frame length latched at start; stays still while the link runs
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            last_bit <= '1;
        end else if (accept) begin
            last_bit <= {fw_m1[WIDX-1:0], 5'h1f};
        end
    end

    // Transmit words; writes during a ready phase are ignored
    always_ff @(posedge clk_sys) begin
        if (tx_wr_en && (state != SRHS_READY)) begin
            tx_buf[tx_wr_idx] <= tx_wr_data;
        end
    end

    // Receive words are only stable between frame_done and the next ready
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_rd_data <= '0;
        end else begin
            rx_rd_data <= rx_buf[rx_rd_idx];
        end
    end

    // Frame end pulse toward the user
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            frame_done <= 1'b0;
        end else begin
            frame_done <= done_evt && (state == SRHS_READY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the system clock

    // Master ready is an asynchronous pin: two flops before any logic
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mr_s1 <= 1'b0;
            mr_s2 <= 1'b0;
            mr_s3 <= 1'b0;
            master_wake <= 1'b0;
        end else begin
            mr_s1 <= master_ready_line;
            mr_s2 <= mr_s1;
            mr_s3 <= mr_s2;
            master_wake <= mr_s2 && !mr_s3;
        end
    end
    assign master_ready = mr_s2;

    // Frame end travels as a toggle; edge taken after the second flop
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
        end else begin
            done_s1 <= done_tgl;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side on the master clock, which stops between frames

    // Both counters at zero only between frames; a frame has 32 bits or more
    assign link_idle = (rcnt == '0) && (fcnt == '0);

    // Clock is input only; first bit shown from the buffer while idle
    assign spi_miso = link_idle ? tx_buf[0][31] : miso_q;

    // Rising edge shifts the next bit out, MSB of word 0 first
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt <= '0;
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_buf[rcnt[BW-1:5]][~rcnt[4:0]];
            rcnt <= (rcnt == last_bit) ? '0 : rcnt + BW'(1);
        end
    end

    // Falling edge counts samples and flags the last one
    always_ff @(negedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            fcnt <= '0;
            done_tgl <= 1'b0;
        end else if (fcnt == last_bit) begin
            fcnt <= '0;
            done_tgl <= ~done_tgl;
        end else begin
            fcnt <= fcnt + BW'(1);
        end
    end

    // Falling edge samples the master's data into the receive words
    always_ff @(negedge spi_sclk) begin
        rx_buf[fcnt[BW-1:5]][~fcnt[4:0]] <= spi_mosi;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the system side

    sequence s_frame_end;
        done_evt && (state == SRHS_READY);
    endsequence

    sequence s_low_prep;
        !slave_ready_line [*2];
    endsequence

    a_send_raises_ready: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (state == SRHS_IDLE && send && len_ok) |=> slave_ready_line ##0 busy)
        else $error("ready not raised after send");

    a_ready_drops: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_frame_end |=> frame_done ##0 s_low_prep)
        else $error("ready not dropped after frame");

    a_restart_quick: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_frame_end ##0 pend) |-> ##3 (slave_ready_line || !len_ok))
        else $error("pending send not restarted");

    a_wake_synced: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |-> (master_wake == ($past(master_ready_line, 3)
            && !$past(master_ready_line, 4))))
        else $error("wake not tied to synced master ready edge");

    a_wake_single: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        master_wake |-> master_ready ##1 !master_wake)
        else $error("wake pulse malformed");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the link side

    a_first_bit: assert property (
        @(posedge spi_sclk) disable iff (!rst_n)
        link_idle |-> (spi_miso == tx_buf[0][31]) ##1 (spi_miso == $past(spi_miso)))
        else $error("first bit not presented before first rise");

    a_miso_order: assert property (
        @(negedge spi_sclk) disable iff (!rst_n)
        1'b1 |-> (spi_miso == tx_buf[fcnt[BW-1:5]][~fcnt[4:0]]))
        else $error("output bit out of order");

    a_frame_len: assert property (
        @(negedge spi_sclk) disable iff (!rst_n)
        $changed(done_tgl) |-> ($past(fcnt) == $past(last_bit)) && (fcnt == '0))
        else $error("frame ended at wrong bit count");

    a_rx_capture: assert property (
        @(negedge spi_sclk) disable iff (!rst_n)
        1'b1 |=> (rx_buf[$past(fcnt[BW-1:5])][~$past(fcnt[4:0])]
            == $past(spi_mosi)))
        else $error("input bit not stored");

endmodule : srhs_link
`default_nettype wire

/* File: srhs_link_tb.sv */
// Self-checking bench of the ready-handshake link slave
`timescale 1ns/1ps
`default_nettype none
module srhs_link_tb;
    typedef struct {int n; logic [31:0] txb; logic [31:0] mob;} srhs_row_t;
    srhs_row_t rows [3] = '{'{1, 32'h8000_0001, 32'h7ffe_0003},
        '{2, 32'ha5c3_0f96, 32'h5a3c_f069}, '{8, 32'h0123_4567, 32'hfedc_ba98}};
    logic clk_sys, rst_n, spi_sclk, spi_mosi, spi_miso, master_ready_line;
    logic slave_ready_line, tx_wr_en, send, frame_done, master_ready, master_wake, busy;
    logic [2:0] tx_wr_idx, rx_rd_idx;
    logic [31:0] tx_wr_data, rx_rd_data;
    logic [3:0] frame_words;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    srhs_link i_srhs_link (.clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .master_ready_line(master_ready_line),
        .slave_ready_line(slave_ready_line), .tx_wr_en(tx_wr_en), .tx_wr_idx(tx_wr_idx),
        .tx_wr_data(tx_wr_data), .frame_words(frame_words), .send(send),
        .rx_rd_idx(rx_rd_idx), .rx_rd_data(rx_rd_data), .frame_done(frame_done),
        .master_ready(master_ready), .master_wake(master_wake), .busy(busy));
    srhs_master_model i_srhs_master_model (.slave_ready_line(slave_ready_line),
        .spi_miso(spi_miso), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .master_ready_line(master_ready_line));
    ////////////////////////////////////////////////////////////////////////////////
    // System clock, 100 ns
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // A hang ends the run as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    // Inputs move 10 ns after the edge, outputs are looked at then too
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #10;
    endtask : tick
    // Load words, request, let the master clock, then read both directions back
    task automatic run_frame(input int n, input logic [31:0] tb, input logic [31:0] mb,
        input logic hold);
        for (int i = 0; i < n; i++) begin
            tx_wr_en = 1'b1;
            tx_wr_idx = 3'(i);
            tx_wr_data = tb + i * 32'h0101_0101;
            i_srhs_master_model.m_tx[i] = mb + i * 32'h0101_0101;
            tick(1);
        end
        tx_wr_en = 1'b0;
        frame_words = 4'(n);
        send = 1'b1;
        tick(1);
        chk_bit("slave_ready_line", 1'b1, slave_ready_line);
        // Send held one more cycle leaves a request pending for the restart
        send = hold;
        tick(1);
        send = 1'b0;
        i_srhs_master_model.frame(n);
        for (int k = 0; k < 20 && frame_done !== 1'b1; k++) tick(1);
        chk_bit("frame_done", 1'b1, frame_done);
        chk_bit("slave_ready_line", 1'b0, slave_ready_line);
        for (int i = 0; i < n; i++) begin
            rx_rd_idx = 3'(i);
            tick(1);
            chk_word("rx_rd_data", mb + i * 32'h0101_0101, rx_rd_data);
            chk_word("master rx", tb + i * 32'h0101_0101,
                i_srhs_master_model.m_rx[i]);
        end
    endtask : run_frame
    // Reset, wake case, table of frames, then restart case
    initial begin
        {rst_n, send, tx_wr_en, tx_wr_idx, tx_wr_data, rx_rd_idx} = '0;
        frame_words = 4'h1;
        tick(5);
        chk_bit("slave_ready_line", 1'b0, slave_ready_line);
        chk_bit("busy", 1'b0, busy);
        rst_n = 1'b1;
        i_srhs_master_model.set_ready(1'b1);
        tick(2);
        chk_bit("master_ready", 1'b1, master_ready);
        tick(1);
        chk_bit("master_wake", 1'b1, master_wake);
        tick(1);
        chk_bit("master_wake", 1'b0, master_wake);
        foreach (rows[r]) run_frame(rows[r].n, rows[r].txb, rows[r].mob, 1'b0);
        tick(3);
        chk_bit("busy", 1'b0, busy);
        run_frame(1, 32'hc001_d00d, 32'h1357_9bdf, 1'b1);
        chk_bit("slave_ready_line", 1'b0, slave_ready_line);
        tick(1);
        chk_bit("slave_ready_line", 1'b1, slave_ready_line);
        send = 1'b0;
        i_srhs_master_model.set_ready(1'b0);
        i_srhs_master_model.frame(1);
        tick(10);
        chk_word("master rx", 32'hc001_d00d, i_srhs_master_model.m_rx[0]);
        chk_bit("busy", 1'b0, busy);
        chk_bit("master_ready", 1'b0, master_ready);
        wrap_up();
    end
endmodule : srhs_link_tb
`default_nettype wire

/* File: srhs_master_model.sv */
// Behavioural master of the ready-handshake link
`timescale 1ns/1ps
`default_nettype none
module srhs_master_model (
    input wire logic slave_ready_line,
    input wire logic spi_miso,
    output logic spi_sclk,
    output logic spi_mosi,
    output logic master_ready_line
);
    logic [31:0] m_tx [8];
    logic [31:0] m_rx [8];
    ////////////////////////////////////////////////////////////////////////////////
    // Idle levels: clock low, data line pulled high
    initial begin
        spi_sclk = 1'b0;
        spi_mosi = 1'b1;
        master_ready_line = 1'b0;
    end
    // Clock stands still outside a frame, so the link domain sees no stray edges
    task automatic frame(input int n);
        // On a restart the slave is already ready, so the line may stay as it is
        if (slave_ready_line !== 1'b1) begin
            master_ready_line = 1'b1;
        end
        wait (slave_ready_line === 1'b1);
        #37;
        for (int i = 0; i < 32 * n; i++) begin
            spi_sclk = 1'b1;
            spi_mosi = m_tx[i / 32][31 - i % 32];
            #62.5;
            spi_sclk = 1'b0;
            m_rx[i / 32][31 - i % 32] = spi_miso;
            #62.5;
        end
        spi_mosi = 1'b1;
    endtask : frame
    // Either level is legal for the master line around a restart
    task automatic set_ready(input logic v);
        master_ready_line = v;
    endtask : set_ready
endmodule : srhs_master_model
`default_nettype wire

/* File: srhs_params.svh */
// Constants of the ready-handshake serial link slave
`ifndef SRHS_PARAMS_SVH
`define SRHS_PARAMS_SVH
`define SRHS_WORD_BITS 32
`define SRHS_HDR_WORDS 1
`define SRHS_FRAME_WORDS_MAX 8
`define SRHS_CLK_NS 100
`define SRHS_PREP_NS 200
`define SRHS_PREP_CYC ((`SRHS_PREP_NS + `SRHS_CLK_NS - 1) / `SRHS_CLK_NS)
`endif

/* File: srhs_pkg.sv */
// Types of the ready-handshake serial link slave
`default_nettype none
package srhs_pkg;
    // Handshake states of the system side
    typedef enum logic [1:0] {
        SRHS_IDLE,
        SRHS_READY,
        SRHS_PREP
    } srhs_state_t;
endpackage : srhs_pkg
`default_nettype wire
